// File: adc_warmup_ctrl.sv
// ADC core warm-up and ready-interrupt control block.
// Assumes power-up requests come from other logic or pins, async to mclk.
//
// How it works
// - The four-bit warm-up field selects 16 to 32768 core clock periods by doubling steps.
// - Codes with the upper two bits zero give the 16-period minimum.
// - With the shared-core enable set, a shared core ready event raises the interrupt.
// - With the shared-core enable clear, the shared ready event does not interrupt.
// - Bits 3 to 0 enable the interrupt for dedicated cores 3 to 0 on their ready event.
// - With a dedicated core enable clear, that core's ready event does not interrupt.
// - Bits 15-12 and 6-4 of the control register read zero and ignore writes.
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module adc_warmup_ctrl #(
    parameter int NCORE = warmup_pkg::NUM_CORES
) (
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    // Register port
    input wire logic [1:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    // Core power requests, index 4 is the shared core
    input wire logic [4:0] core_power_req,
    // Core ready and interrupt
    output logic [4:0] core_ready,
    output logic irq
);
    import warmup_pkg::*;

    logic [15:0] ctrl_r;
    logic [4:0] stat_r;
    logic [4:0] mask_r;
    logic [4:0] s1_r, s2_r, s3_r, pwr_r;
    logic [15:0] limit_nxt;
    logic [4:0] rdy_w, evt_w, en_w, hit_w;
    logic [4:0] ready_r;
    logic irq_r;
    logic [15:0] rdata_r;

    // Three-stage synchroniser, change accepted when stages 2 and 3 agree
    always_ff @(posedge mclk) begin
        if (rst) begin
            s1_r <= STAT_RESET;
            s2_r <= STAT_RESET;
            s3_r <= STAT_RESET;
            pwr_r <= STAT_RESET;
        end else if (ce) begin
            s1_r <= core_power_req;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (int i = 0; i < NCORE; i++) begin
                if (s2_r[i] == s3_r[i]) begin
                    pwr_r[i] <= s3_r[i];
                end
            end
        end
    end

    // Warm-up count decode; shift keeps one shared limit for all cores
    always_comb begin
        limit_nxt = MIN_PERIODS;
        if (ctrl_r[WARM_MSB:WARM_LSB] >= WARM_MIN_CODE) begin
            limit_nxt = MIN_PERIODS << (ctrl_r[WARM_MSB:WARM_LSB] - WARM_MIN_CODE);
        end
    end

    // Core counters, one per core
    genvar g;
    generate
        for (g = 0; g < NCORE; g++) begin : g_core
            core_link_if lnk ();
            assign lnk.powered = pwr_r[g];
            assign lnk.limit = limit_nxt;
            assign rdy_w[g] = lnk.ready;
            assign evt_w[g] = lnk.ready_evt;
            core_warmup_counter u_cnt (
                .mclk(mclk),
                .rst(rst),
                .ce(ce),
                .lnk(lnk)
            );
        end
    endgenerate

    // Enable gating of ready events
    assign en_w = {ctrl_r[SHR_EN_BIT], ctrl_r[3:0]};
    assign hit_w = evt_w & en_w;

    // Control register; unimplemented bits never stored
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_r <= CTRL_RESET;
        end else if (ce && wr && addr == CTRL_ADDR) begin
            ctrl_r <= wdata & CTRL_WMASK;
        end
    end

    // Sticky status, write one to clear; a new event wins over the clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            stat_r <= STAT_RESET;
        end else if (ce) begin
            if (wr && addr == STAT_ADDR) begin
                stat_r <= (stat_r & ~wdata[4:0]) | hit_w;
            end else begin
                stat_r <= stat_r | hit_w;
            end
        end
    end

    // Interrupt mask, set bit passes status
    always_ff @(posedge mclk) begin
        if (rst) begin
            mask_r <= MASK_RESET;
        end else if (ce && wr && addr == MASK_ADDR) begin
            mask_r <= wdata[4:0];
        end
    end

    // Registered outputs
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_r <= 1'b0;
            ready_r <= STAT_RESET;
        end else if (ce) begin
            irq_r <= |(stat_r & mask_r);
            ready_r <= rdy_w;
        end
    end

    // Read data one cycle after strobe, zero otherwise
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_r <= ZERO16;
        end else if (ce) begin
            rdata_r <= ZERO16;
            if (rd) begin
                unique case (addr)
                    CTRL_ADDR: rdata_r <= ctrl_r & CTRL_WMASK;
                    STAT_ADDR: rdata_r <= {11'h000, stat_r};
                    MASK_ADDR: rdata_r <= {11'h000, mask_r};
                    RDY_ADDR: rdata_r <= {11'h000, rdy_w};
                endcase
            end
        end
    end

    assign rdata = rdata_r;
    assign irq = irq_r;
    assign core_ready = ready_r;

    // Unimplemented control bits never hold a one
    AST_RSVD_ZERO: assert property (@(posedge mclk) disable iff (rst)
        !rst
        |-> (ctrl_r & ~CTRL_WMASK) == ZERO16)
        else $error("reserved control bits set");

    // A control write keeps only the implemented bits
    AST_CTRL_WR: assert property (@(posedge mclk) disable iff (rst)
        (ce && wr && addr == CTRL_ADDR)
        |=> ctrl_r == ($past(wdata) & CTRL_WMASK))
        else $error("control write wrong");

    // Control read returns the stored value
    AST_RD_CTRL: assert property (@(posedge mclk) disable iff (rst)
        (ce && rd && addr == CTRL_ADDR)
        |=> rdata_r == $past(ctrl_r))
        else $error("control readback wrong");

    // Status read shows the sticky bits with the upper bits zero
    AST_RD_STAT: assert property (@(posedge mclk) disable iff (rst)
        (ce && rd && addr == STAT_ADDR)
        |=> rdata_r == {11'h000, $past(stat_r)})
        else $error("status readback wrong");

    // Mask read shows the mask with the upper bits zero
    AST_RD_MASK: assert property (@(posedge mclk) disable iff (rst)
        (ce && rd && addr == MASK_ADDR)
        |=> rdata_r == {11'h000, $past(mask_r)})
        else $error("mask readback wrong");

    // Ready view read shows the counters' ready levels
    AST_RD_RDY: assert property (@(posedge mclk) disable iff (rst)
        (ce && rd && addr == RDY_ADDR)
        |=> rdata_r == {11'h000, $past(rdy_w)})
        else $error("ready view readback wrong");

    // Without a read strobe the data lines return to zero
    AST_RD_IDLE: assert property (@(posedge mclk) disable iff (rst)
        (ce && !rd)
        |=> rdata_r == ZERO16)
        else $error("read data not idle");

    // Codes with the upper two bits clear give the minimum
    AST_MIN_CODE: assert property (@(posedge mclk) disable iff (rst)
        (ctrl_r[WARM_MSB:WARM_MSB-1] == 2'h0)
        |-> limit_nxt == MIN_PERIODS)
        else $error("minimum warm-up wrong");

    // Lowest full code gives 16 periods
    AST_CODE4: assert property (@(posedge mclk) disable iff (rst)
        (ctrl_r[WARM_MSB:WARM_LSB] == 4'h4)
        |-> limit_nxt == 16'h0010)
        else $error("code 4 warm-up wrong");

    // One step up doubles to 32 periods
    AST_CODE5: assert property (@(posedge mclk) disable iff (rst)
        (ctrl_r[WARM_MSB:WARM_LSB] == 4'h5)
        |-> limit_nxt == 16'h0020)
        else $error("code 5 warm-up wrong");

    // Middle code gives 256 periods
    AST_CODE8: assert property (@(posedge mclk) disable iff (rst)
        (ctrl_r[WARM_MSB:WARM_LSB] == 4'h8)
        |-> limit_nxt == 16'h0100)
        else $error("code 8 warm-up wrong");

    // Second code from the top gives 16384 periods
    AST_CODE14: assert property (@(posedge mclk) disable iff (rst)
        (ctrl_r[WARM_MSB:WARM_LSB] == 4'he)
        |-> limit_nxt == 16'h4000)
        else $error("code 14 warm-up wrong");

    // Top code gives 32768 periods
    AST_MAX_CODE: assert property (@(posedge mclk) disable iff (rst)
        (ctrl_r[WARM_MSB:WARM_LSB] == 4'hf)
        |-> limit_nxt == 16'h8000)
        else $error("maximum warm-up wrong");

    // Every code gives a power of two, never below the minimum
    AST_LIMIT_ONEHOT: assert property (@(posedge mclk) disable iff (rst)
        !rst
        |-> $onehot(limit_nxt) && limit_nxt >= MIN_PERIODS)
        else $error("warm-up limit not a power of two");

    // Enabled shared event latches
    AST_SHR_SET: assert property (@(posedge mclk) disable iff (rst)
        (ce && evt_w[SHR_IDX] && ctrl_r[SHR_EN_BIT])
        |=> stat_r[SHR_IDX])
        else $error("shared event lost");

    // Disabled shared event never reaches status
    AST_SHR_GATED: assert property (@(posedge mclk) disable iff (rst)
        (ce && evt_w[SHR_IDX] && !ctrl_r[SHR_EN_BIT] && !stat_r[SHR_IDX]
         && !(wr && addr == STAT_ADDR)) |=> !stat_r[SHR_IDX])
        else $error("shared event not gated");

    // Enabled core 0 event latches
    AST_C0_SET: assert property (@(posedge mclk) disable iff (rst)
        (ce && evt_w[0] && ctrl_r[0])
        |=> stat_r[0])
        else $error("core0 event lost");

    // Disabled core 0 event ignored
    AST_C0_GATED: assert property (@(posedge mclk) disable iff (rst)
        (ce && evt_w[0] && !ctrl_r[0] && !stat_r[0]
         && !(wr && addr == STAT_ADDR)) |=> !stat_r[0])
        else $error("core0 event not gated");

    // Enabled core 1 event latches
    AST_C1_SET: assert property (@(posedge mclk) disable iff (rst)
        (ce && evt_w[1] && ctrl_r[1])
        |=> stat_r[1])
        else $error("core1 event lost");

    // Disabled core 1 event ignored
    AST_C1_GATED: assert property (@(posedge mclk) disable iff (rst)
        (ce && evt_w[1] && !ctrl_r[1] && !stat_r[1]
         && !(wr && addr == STAT_ADDR)) |=> !stat_r[1])
        else $error("core1 event not gated");

    // Enabled core 2 event latches
    AST_C2_SET: assert property (@(posedge mclk) disable iff (rst)
        (ce && evt_w[2] && ctrl_r[2])
        |=> stat_r[2])
        else $error("core2 event lost");

    // Disabled core 2 event ignored
    AST_C2_GATED: assert property (@(posedge mclk) disable iff (rst)
        (ce && evt_w[2] && !ctrl_r[2] && !stat_r[2]
         && !(wr && addr == STAT_ADDR)) |=> !stat_r[2])
        else $error("core2 event not gated");

    // Enabled core 3 event latches
    AST_C3_SET: assert property (@(posedge mclk) disable iff (rst)
        (ce && evt_w[3] && ctrl_r[3])
        |=> stat_r[3])
        else $error("core3 event lost");

    // Disabled core 3 event ignored
    AST_C3_GATED: assert property (@(posedge mclk) disable iff (rst)
        (ce && evt_w[3] && !ctrl_r[3] && !stat_r[3]
         && !(wr && addr == STAT_ADDR)) |=> !stat_r[3])
        else $error("core3 event not gated");

    // Writing a one clears a status bit when no event comes with it
    AST_STAT_CLEAR: assert property (@(posedge mclk) disable iff (rst)
        (ce && wr && addr == STAT_ADDR && wdata[1] && !hit_w[1])
        |=> !stat_r[1])
        else $error("status clear lost");

    // An event in the cycle of a clear still sets its bit
    AST_STAT_SET_WINS: assert property (@(posedge mclk) disable iff (rst)
        (ce && wr && addr == STAT_ADDR && wdata[0] && hit_w[0])
        |=> stat_r[0])
        else $error("clear beat a new event");

    // Interrupt follows masked status one cycle later
    AST_IRQ: assert property (@(posedge mclk) disable iff (rst)
        ce
        |=> irq_r == ($past(stat_r & mask_r) != 5'h00))
        else $error("irq mismatch");

    // A settled synchroniser passes its level on
    AST_PWR_FOLLOW: assert property (@(posedge mclk) disable iff (rst)
        (ce && s2_r == s3_r)
        |=> pwr_r == $past(s3_r))
        else $error("power level not taken");

    // Ready output is the counters' level one cycle on
    AST_READY_OUT: assert property (@(posedge mclk) disable iff (rst)
        ce
        |=> ready_r == $past(rdy_w))
        else $error("ready output wrong");

    // A ready event lasts one enabled cycle
    AST_EVT_PULSE: assert property (@(posedge mclk) disable iff (rst)
        (ce && evt_w[SHR_IDX])
        |=> !evt_w[SHR_IDX])
        else $error("ready event longer than a cycle");

    // Clock enable low freezes the registers
    AST_HOLD_REGS: assert property (@(posedge mclk) disable iff (rst)
        !ce
        |=> $stable(ctrl_r) && $stable(stat_r) && $stable(mask_r))
        else $error("register moved with enable low");

    // Clock enable low freezes the outputs
    AST_HOLD_OUT: assert property (@(posedge mclk) disable iff (rst)
        !ce
        |=> $stable(irq_r) && $stable(ready_r) && $stable(rdata_r))
        else $error("output moved with enable low");

    // Clock enable low freezes the synchroniser too
    AST_HOLD_SYNC: assert property (@(posedge mclk) disable iff (rst)
        !ce
        |=> $stable(s1_r) && $stable(s2_r) && $stable(s3_r) && $stable(pwr_r))
        else $error("synchroniser moved with enable low");
endmodule : adc_warmup_ctrl
`default_nettype wire

// File: warmup_pkg.sv
// Package for ADC core warm-up and ready-interrupt control.
// Assumes one core source clock domain; imported by the controller, the counter and the bench.
package warmup_pkg;
    localparam int NUM_CORES = 5;
    localparam int DLY_W = 16;
    // Register map (16-bit registers, word index)
    localparam logic [1:0] CTRL_ADDR = 2'h0;
    localparam logic [1:0] STAT_ADDR = 2'h1;
    localparam logic [1:0] MASK_ADDR = 2'h2;
    localparam logic [1:0] RDY_ADDR = 2'h3;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] CTRL_WMASK = 16'h0f8f;
    localparam int WARM_LSB = 8;
    localparam int WARM_MSB = 11;
    localparam int SHR_EN_BIT = 7;
    localparam int SHR_IDX = 4;
    localparam logic [3:0] WARM_MIN_CODE = 4'h4;
    localparam logic [15:0] MIN_PERIODS = 16'h0010;
    localparam logic [4:0] STAT_RESET = 5'h00;
    localparam logic [4:0] MASK_RESET = 5'h1f;
    localparam logic [15:0] ZERO16 = 16'h0000;
endpackage : warmup_pkg

// File: core_link_if.sv
// Per-core warm-up handshake between control and counter.
// Assumes one instance per ADC core, same clock domain.
`timescale 1ns/1ns
`default_nettype none
interface core_link_if;
    logic powered;
    logic [15:0] limit;
    logic ready;
    logic ready_evt;
    modport ctl (output powered, output limit, input ready, input ready_evt);
    modport cnt (input powered, input limit, output ready, output ready_evt);
endinterface : core_link_if
`default_nettype wire

// File: core_warmup_counter.sv
// Warm-up counter for one ADC core.
// Assumes power request already synchronised to mclk.
`timescale 1ns/1ns
`default_nettype none
module core_warmup_counter (
    // Clock and control
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    // Link to control
    core_link_if.cnt lnk
);
    import warmup_pkg::*;
    logic [15:0] cnt_r;
    logic ready_r;
    logic evt_r;

    // Count periods while powered; restart when power drops
    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_r <= ZERO16;
            ready_r <= 1'b0;
            evt_r <= 1'b0;
        end else if (ce) begin
            evt_r <= 1'b0;
            if (!lnk.powered) begin
                cnt_r <= ZERO16;
                ready_r <= 1'b0;
            end else if (!ready_r) begin
                if (cnt_r + 16'h0001 >= lnk.limit) begin
                    ready_r <= 1'b1;
                    evt_r <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 16'h0001;
                end
            end
        end
    end
    assign lnk.ready = ready_r;
    assign lnk.ready_evt = evt_r;

    // Ready must never come before power was seen
    AST_NO_READY_UNPOWERED: assert property (@(posedge mclk) disable iff (rst)
        (ce && !lnk.powered) |=> !ready_r) else $error("ready without power");
endmodule : core_warmup_counter
`default_nettype wire

// File: core_power_model.sv
// Behavioural ADC core power sequencer facing the warm-up block.
// Assumes the bench picks which cores to power; one mclk domain.
`timescale 1ns/1ns
`default_nettype none
module core_power_model (
    // Clock
    input wire logic mclk,
    // Bench command and core power lines
    input wire logic [4:0] cmd,
    output logic [4:0] core_power_req
);
    // Power lines change just after an edge, as real sequencing would
    always @(posedge mclk) begin
        core_power_req <= cmd;
    end
endmodule : core_power_model
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the warm-up and ready-interrupt block.
// Assumes the package, interface, design and power model compile first.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import warmup_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [1:0] addr = 2'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [4:0] cmd = 5'h00;
    logic [15:0] rdata;
    logic [4:0] pwr;
    logic [4:0] core_ready;
    logic irq;
    logic [15:0] rv;
    int fail_count = 0;
    int n_checks = 0;
    int n;
    int n_base;
    // Rows: value written to control, value read back
    logic [15:0] rows [4][2] = '{'{16'hffff, 16'h0f8f}, '{16'h0481, 16'h0481},
        '{16'hf070, 16'h0000}, '{16'h0b05, 16'h0b05}};
    // Warm-up codes and extra periods over the 16-period minimum
    logic [3:0] codes [5] = '{4'h4, 4'h5, 4'h7, 4'h0, 4'h3};
    int extra [5] = '{0, 16, 112, 0, 0};

    // 50 MHz clock
    always #10 mclk = ~mclk;

    core_power_model i_core_power_model (.mclk(mclk), .cmd(cmd), .core_power_req(pwr));
    adc_warmup_ctrl i_adc_warmup_ctrl (.mclk(mclk), .rst(rst), .ce(ce), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .core_power_req(pwr),
        .core_ready(core_ready), .irq(irq));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [1:0] a, output logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    // Powers one core and counts cycles until it reports ready
    task automatic warm(input int core, output int cnt);
        cnt = 0;
        @(posedge mclk);
        cmd <= 5'h01 << core;
        do begin
            @(posedge mclk);
            #1 cnt++;
        end while (core_ready[core] !== 1'b1 && cnt < 40000);
    endtask : warm

    task automatic drop(input int core);
        @(posedge mclk);
        cmd <= 5'h00;
        repeat (10) @(posedge mclk);
        #1 check("ready after power off", 16'(core_ready[core]), 16'h0000);
    endtask : drop

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    // Hang guard at 10,000 cycles, several times the expected run
    initial begin
        #200_000;
        fail_count++;
        results();
    end

    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            wr_reg(CTRL_ADDR, rows[i][0]);
            rd_reg(CTRL_ADDR, rv);
            check("ctrl readback", rv, rows[i][1]);
        end
        $display("test register rows done");
        // Mid-run reset brings every register back
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rd_reg(CTRL_ADDR, rv);
        check("ctrl reset", rv, CTRL_RESET);
        rd_reg(STAT_ADDR, rv);
        check("status reset", rv, 16'h0000);
        rd_reg(MASK_ADDR, rv);
        check("mask reset", rv, {11'h000, MASK_RESET});
        check("irq reset", 16'(irq), 16'h0000);
        $display("test reset done");
        // Warm-up length per code, measured against code 4
        foreach (codes[i]) begin
            wr_reg(CTRL_ADDR, {4'h0, codes[i], 8'h00});
            warm(0, n);
            if (i == 0) n_base = n;
            check("warm periods", 16'(n - n_base), 16'(extra[i]));
            drop(0);
        end
        check("minimum warm-up", 16'(n_base >= 16), 16'h0001);
        $display("test warm-up codes done");
        // Each core with its enable clear, then set
        for (int c = 0; c < 5; c++) begin
            for (int e = 0; e < 2; e++) begin
                wr_reg(CTRL_ADDR, 16'(e) << ((c == SHR_IDX) ? SHR_EN_BIT : c));
                warm(c, n);
                repeat (3) @(posedge mclk);
                rd_reg(RDY_ADDR, rv);
                check("ready view", rv, 16'h0001 << c);
                rd_reg(STAT_ADDR, rv);
                check("status", rv, 16'(e) << c);
                check("irq", 16'(irq), 16'(e));
                wr_reg(STAT_ADDR, 16'h001f);
                drop(c);
                check("irq cleared", 16'(irq), 16'h0000);
            end
        end
        $display("test core enables done");
        // Masked event holds off the line until unmasked
        wr_reg(MASK_ADDR, 16'h0000);
        wr_reg(CTRL_ADDR, 16'h0002);
        warm(1, n);
        repeat (3) @(posedge mclk);
        #1 check("masked irq", 16'(irq), 16'h0000);
        wr_reg(MASK_ADDR, 16'h001f);
        repeat (2) @(posedge mclk);
        #1 check("unmasked irq", 16'(irq), 16'h0001);
        wr_reg(STAT_ADDR, 16'h0002);
        drop(1);
        check("irq after clear", 16'(irq), 16'h0000);
        $display("test mask done");
        // Clear strobe lands in the very cycle of the ready event: the event wins
        wr_reg(CTRL_ADDR, 16'h0001);
        @(posedge mclk);
        cmd <= 5'h01;
        repeat (20) @(posedge mclk);
        wr_reg(STAT_ADDR, 16'h0001);
        rd_reg(STAT_ADDR, rv);
        check("event over clear", rv, 16'h0001);
        wr_reg(STAT_ADDR, 16'h0001);
        drop(0);
        $display("test clear race done");
        // Enable low freezes count, sync stages and registers; a write is ignored
        @(posedge mclk);
        ce <= 1'b0;
        cmd <= 5'h01;
        repeat (40) @(posedge mclk);
        wr_reg(CTRL_ADDR, 16'h0000);
        ce <= 1'b1;
        #1 check("frozen ready", 16'(core_ready), 16'h0000);
        repeat (30) @(posedge mclk);
        #1 check("ready after enable", 16'(core_ready), 16'h0001);
        check("irq after enable", 16'(irq), 16'h0001);
        rd_reg(CTRL_ADDR, rv);
        check("ctrl frozen", rv, 16'h0001);
        $display("test clock enable done");
        results();
    end
endmodule : testbench
`default_nettype wire
